// >>> rtl/mpt_pkg.sv
package mpt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int unsigned CNT_W = 15;
    localparam int unsigned REG_W = 16;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned PAIRS = 3;
    localparam int unsigned PRE_W = 6;
    localparam int unsigned POST_W = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [ADDR_W-1:0] OFS_TCON = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_TMR = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_TPER = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SECMP = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CON1 = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_KEY = 8'h14;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned TCON_RUN_BIT = 15;
    localparam int unsigned TCON_IDLE_BIT = 13;
    localparam int unsigned TCON_OPS_LSB = 4;
    localparam int unsigned TCON_CKPS_LSB = 2;
    localparam int unsigned TCON_MOD_LSB = 0;
    localparam int unsigned TMR_DIR_BIT = 15;
    localparam int unsigned SECMP_DIR_BIT = 15;
    localparam int unsigned CON1_PAIR_INDEPENDENT_LSB = 8;
    localparam int unsigned CON1_PENH_LSB = 4;
    localparam int unsigned CON1_PENL_LSB = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and constants
    localparam logic [REG_W-1:0] TCON_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 15'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 15'h0001;
    localparam logic [REG_W-1:0] SECMP_RST = 16'h0000;
    localparam logic [PAIRS-1:0] PAIR_RST = 3'h0;
    localparam logic [POST_W-1:0] POST_ZERO = 4'h0;
    localparam logic [POST_W-1:0] POST_ONE = 4'h1;
    localparam logic [PRE_W-1:0] PRE_ZERO = 6'h00;
    localparam logic [PRE_W-1:0] PRE_ONE = 6'h01;
    localparam logic [REG_W-1:0] KEY_FIRST = 16'hABCD;
    localparam logic [REG_W-1:0] KEY_SECOND = 16'h4321;
    localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

    // Time base count modes
    localparam logic [1:0] MODE_FREE = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_UPDOWN = 2'h2;
    localparam logic [1:0] MODE_UPDOWN_DBL = 2'h3;

    // Prescaler terminal counts for 1:1, 1:4, 1:16, 1:64
    localparam logic [PRE_W-1:0] PRE_TC_1 = 6'h00;
    localparam logic [PRE_W-1:0] PRE_TC_4 = 6'h03;
    localparam logic [PRE_W-1:0] PRE_TC_16 = 6'h0F;
    localparam logic [PRE_W-1:0] PRE_TC_64 = 6'h3F;

    typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} mpt_key_t;

    function automatic logic [PRE_W-1:0] mpt_pre_tc(input logic [1:0] code);
        case (code)
            2'h0: mpt_pre_tc = PRE_TC_1;
            2'h1: mpt_pre_tc = PRE_TC_4;
            2'h2: mpt_pre_tc = PRE_TC_16;
            default: mpt_pre_tc = PRE_TC_64;
        endcase
    endfunction : mpt_pre_tc

endpackage : mpt_pkg

// >>> rtl/mpt_prescale.sv
module mpt_prescale import mpt_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic [1:0] in_prescale,
    output logic tick
);

    typedef struct packed {
        logic [PRE_W-1:0] cnt;
        logic tick;
    } mpt_pre_state_t;

    localparam mpt_pre_state_t PRE_RST = '{cnt: PRE_ZERO, tick: 1'b0};

    mpt_pre_state_t st_ff;
    mpt_pre_state_t nxt_st;

    // Divides the clock into one-cycle ticks at 1, 4, 16 or 64 cycles
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (!run) begin
            nxt_st.cnt = PRE_ZERO;
        end else if (st_ff.cnt >= mpt_pre_tc(in_prescale)) begin
            nxt_st.cnt = PRE_ZERO;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + PRE_ONE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= PRE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;

endmodule : mpt_prescale

// >>> rtl/mpt_top.sv
//////////////////////////////////////////////////////////////////////////////
// Function
// - Time base counts only while timebase_run is set.
// - With idle_halt set, the time base stops while the processor idles.
// - Output events divided by out_postscale plus one, 1:1 to 1:16.
// - Count clock is hclk divided by 1, 4, 16 or 64.
// - Mode 00 runs the time base free.
// - Mode 01 gives one pulse then clears timebase_run.
// - Mode 10 counts continuously up and down.
// - Mode 11 counts up and down with events at both turning points.
// - count_down_flag reads at count bit 15; writes leave it unchanged.
// - Count value readable and writable in bits 14-0.
// - Period held in bits 14-0, bit 15 reads zero.
// - Special event fires when compare value equals the count.
// - Special event only when event_direction equals count_down_flag.
// - pair_independent bit per pair: 1 independent, 0 complementary.
// - high_pin_enable bit gives high pin to the PWM, else released.
// - low_pin_enable bit gives low pin to the PWM, else released.
// - Pin enables after reset follow pin_reset_owner_cfg inverted.
// - Output pair control written only when unlocked or unguarded.
// - Unimplemented bits read zero and ignore writes.
// - Any other access between keys and the write cancels the unlock.
// - Write guard on by default, config strap can disable it.
// - In complementary mode the low pin is the inverse of the high pin.
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
module mpt_top import mpt_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic cpu_idle,
    input wire logic pin_reset_owner_cfg,
    input wire logic write_guard_cfg,
    input wire logic [2:0] pwm_high_src,
    input wire logic [2:0] pwm_low_src,
    output logic [2:0] high_pin_out,
    output logic [2:0] high_pin_oe,
    output logic [2:0] low_pin_out,
    output logic [2:0] low_pin_oe,
    output logic special_event,
    output logic timebase_event
);

    //////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic timebase_run;
        logic idle_halt;
        logic [POST_W-1:0] out_postscale;
        logic [1:0] in_prescale;
        logic [1:0] timebase_count_mode;
        logic [CNT_W-1:0] timebase_count;
        logic count_down_flag;
        logic [CNT_W-1:0] timebase_period;
        logic event_direction;
        logic [CNT_W-1:0] event_compare_value;
        logic [PAIRS-1:0] pair_independent;
        logic [PAIRS-1:0] high_pin_enable;
        logic [PAIRS-1:0] low_pin_enable;
        logic [POST_W-1:0] post_cnt;
        mpt_key_t key;
        logic guard_off;
        logic strap_done;
        logic ap_valid;
        logic ap_write;
        logic [ADDR_W-1:0] ap_addr;
        logic hreadyout;
        logic [DATA_W-1:0] hrdata;
        logic match_prev;
        logic special_event;
        logic timebase_event;
        logic [PAIRS-1:0] high_pin_out;
        logic [PAIRS-1:0] high_pin_oe;
        logic [PAIRS-1:0] low_pin_out;
        logic [PAIRS-1:0] low_pin_oe;
    } mpt_state_t;

    localparam mpt_state_t STATE_RST = '{
        timebase_run: 1'b0,
        idle_halt: 1'b0,
        out_postscale: POST_ZERO,
        in_prescale: 2'h0,
        timebase_count_mode: MODE_FREE,
        timebase_count: CNT_ZERO,
        count_down_flag: 1'b0,
        timebase_period: CNT_ZERO,
        event_direction: 1'b0,
        event_compare_value: CNT_ZERO,
        pair_independent: PAIR_RST,
        high_pin_enable: PAIR_RST,
        low_pin_enable: PAIR_RST,
        post_cnt: POST_ZERO,
        key: KEY_IDLE,
        guard_off: 1'b0,
        strap_done: 1'b0,
        ap_valid: 1'b0,
        ap_write: 1'b0,
        ap_addr: 8'h00,
        hreadyout: 1'b1,
        hrdata: RDATA_ZERO,
        match_prev: 1'b1,
        special_event: 1'b0,
        timebase_event: 1'b0,
        high_pin_out: PAIR_RST,
        high_pin_oe: PAIR_RST,
        low_pin_out: PAIR_RST,
        low_pin_oe: PAIR_RST
    };

    mpt_state_t st_ff;
    mpt_state_t nxt_st;
    logic count_tick;
    logic tb_active;

    //////////////////////////////////////////////////////////////////////////
    // Decoding

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        if (a == OFS_TCON) begin
            is_mapped = 1'b1;
        end else if (a == OFS_TMR) begin
            is_mapped = 1'b1;
        end else if (a == OFS_TPER) begin
            is_mapped = 1'b1;
        end else if (a == OFS_SECMP) begin
            is_mapped = 1'b1;
        end else if (a == OFS_CON1) begin
            is_mapped = 1'b1;
        end else if (a == OFS_KEY) begin
            is_mapped = 1'b1;
        end else begin
            is_mapped = 1'b0;
        end
    endfunction : is_mapped

    function automatic logic [REG_W-1:0] read_reg(input mpt_state_t s, input logic [ADDR_W-1:0] a);
        read_reg = '0;
        if (!is_mapped(a)) begin
            read_reg = '0;
        end else if (a == OFS_TCON) begin
            read_reg[TCON_RUN_BIT] = s.timebase_run;
            read_reg[TCON_IDLE_BIT] = s.idle_halt;
            read_reg[TCON_OPS_LSB +: POST_W] = s.out_postscale;
            read_reg[TCON_CKPS_LSB +: 2] = s.in_prescale;
            read_reg[TCON_MOD_LSB +: 2] = s.timebase_count_mode;
        end else if (a == OFS_TMR) begin
            read_reg[TMR_DIR_BIT] = s.count_down_flag;
            read_reg[CNT_W-1:0] = s.timebase_count;
        end else if (a == OFS_TPER) begin
            read_reg[CNT_W-1:0] = s.timebase_period;
        end else if (a == OFS_SECMP) begin
            read_reg[SECMP_DIR_BIT] = s.event_direction;
            read_reg[CNT_W-1:0] = s.event_compare_value;
        end else if (a == OFS_CON1) begin
            read_reg[CON1_PAIR_INDEPENDENT_LSB +: PAIRS] = s.pair_independent;
            read_reg[CON1_PENH_LSB +: PAIRS] = s.high_pin_enable;
            read_reg[CON1_PENL_LSB +: PAIRS] = s.low_pin_enable;
        end
    endfunction : read_reg

    //////////////////////////////////////////////////////////////////////////
    // Count clock divider

    assign tb_active = st_ff.timebase_run && !(st_ff.idle_halt && cpu_idle);

    mpt_prescale u_prescale (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(tb_active),
        .in_prescale(st_ff.in_prescale),
        .tick(count_tick)
    );

    //////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic raw_event;
        logic match_now;
        logic [REG_W-1:0] wd;
        raw_event = 1'b0;
        match_now = 1'b0;
        wd = hwdata[REG_W-1:0];
        nxt_st = st_ff;
        nxt_st.special_event = 1'b0;
        nxt_st.timebase_event = 1'b0;

        // Straps are caught on the first edge after reset release
        if (!st_ff.strap_done) begin
            nxt_st.strap_done = 1'b1;
            nxt_st.high_pin_enable = {PAIRS{!pin_reset_owner_cfg}};
            nxt_st.low_pin_enable = {PAIRS{!pin_reset_owner_cfg}};
            nxt_st.guard_off = !write_guard_cfg;
        end

        // Time base stepping on each divided tick
        if (tb_active && count_tick) begin
            case (st_ff.timebase_count_mode)
                MODE_FREE: begin
                    nxt_st.count_down_flag = 1'b0;
                    if (st_ff.timebase_count >= st_ff.timebase_period) begin
                        nxt_st.timebase_count = CNT_ZERO;
                        raw_event = 1'b1;
                    end else begin
                        nxt_st.timebase_count = st_ff.timebase_count + CNT_ONE;
                    end
                end
                MODE_SINGLE: begin
                    nxt_st.count_down_flag = 1'b0;
                    if (st_ff.timebase_count >= st_ff.timebase_period) begin
                        nxt_st.timebase_count = CNT_ZERO;
                        nxt_st.timebase_run = 1'b0;
                        raw_event = 1'b1;
                    end else begin
                        nxt_st.timebase_count = st_ff.timebase_count + CNT_ONE;
                    end
                end
                default: begin
                    if (!st_ff.count_down_flag) begin
                        if (st_ff.timebase_count >= st_ff.timebase_period) begin
                            nxt_st.count_down_flag = 1'b1;
                            if (st_ff.timebase_count != CNT_ZERO) begin
                                nxt_st.timebase_count = st_ff.timebase_count - CNT_ONE;
                            end
                            raw_event = (st_ff.timebase_count_mode == MODE_UPDOWN_DBL);
                        end else begin
                            nxt_st.timebase_count = st_ff.timebase_count + CNT_ONE;
                        end
                    end else begin
                        if (st_ff.timebase_count == CNT_ZERO) begin
                            nxt_st.count_down_flag = 1'b0;
                            if (st_ff.timebase_period != CNT_ZERO) begin
                                nxt_st.timebase_count = CNT_ONE;
                            end
                            raw_event = 1'b1;
                        end else begin
                            nxt_st.timebase_count = st_ff.timebase_count - CNT_ONE;
                        end
                    end
                end
            endcase
        end

        // Output postscaler
        if (raw_event) begin
            if (st_ff.post_cnt >= st_ff.out_postscale) begin
                nxt_st.post_cnt = POST_ZERO;
                nxt_st.timebase_event = 1'b1;
            end else begin
                nxt_st.post_cnt = st_ff.post_cnt + POST_ONE;
            end
        end

        // Special event comparator, one pulse per arrival at the match
        match_now = (st_ff.event_compare_value == st_ff.timebase_count)
            && (st_ff.event_direction == st_ff.count_down_flag);
        nxt_st.match_prev = match_now;
        nxt_st.special_event = match_now && !st_ff.match_prev;

        // Bus data phase: one wait state, then answer
        if (st_ff.ap_valid) begin
            nxt_st.ap_valid = 1'b0;
            nxt_st.hreadyout = 1'b1;
            nxt_st.key = KEY_IDLE;
            if (!st_ff.ap_write) begin
                // Read data stands until the next read replaces it
                nxt_st.hrdata = RDATA_ZERO;
                nxt_st.hrdata[REG_W-1:0] = read_reg(st_ff, st_ff.ap_addr);
            end else if (st_ff.ap_addr == OFS_TCON) begin
                nxt_st.timebase_run = wd[TCON_RUN_BIT];
                nxt_st.idle_halt = wd[TCON_IDLE_BIT];
                nxt_st.out_postscale = wd[TCON_OPS_LSB +: POST_W];
                nxt_st.in_prescale = wd[TCON_CKPS_LSB +: 2];
                nxt_st.timebase_count_mode = wd[TCON_MOD_LSB +: 2];
            end else if (st_ff.ap_addr == OFS_TMR) begin
                nxt_st.timebase_count = wd[CNT_W-1:0];
            end else if (st_ff.ap_addr == OFS_TPER) begin
                nxt_st.timebase_period = wd[CNT_W-1:0];
            end else if (st_ff.ap_addr == OFS_SECMP) begin
                nxt_st.event_direction = wd[SECMP_DIR_BIT];
                nxt_st.event_compare_value = wd[CNT_W-1:0];
            end else if (st_ff.ap_addr == OFS_CON1) begin
                if (st_ff.key == KEY_OPEN || st_ff.guard_off) begin
                    nxt_st.pair_independent = wd[CON1_PAIR_INDEPENDENT_LSB +: PAIRS];
                    nxt_st.high_pin_enable = wd[CON1_PENH_LSB +: PAIRS];
                    nxt_st.low_pin_enable = wd[CON1_PENL_LSB +: PAIRS];
                end
            end else if (st_ff.ap_addr == OFS_KEY) begin
                if (wd == KEY_FIRST) begin
                    nxt_st.key = KEY_HALF;
                end else if (st_ff.key == KEY_HALF && wd == KEY_SECOND) begin
                    nxt_st.key = KEY_OPEN;
                end
            end
        end

        // Bus address phase
        if (hsel && htrans[1] && hready) begin
            nxt_st.ap_valid = 1'b1;
            nxt_st.ap_write = hwrite;
            nxt_st.ap_addr = haddr[ADDR_W-1:0];
            nxt_st.hreadyout = 1'b0;
            if (haddr[DATA_W-1:ADDR_W] != '0) begin
                nxt_st.ap_addr = OFS_KEY + 8'h04;
            end
        end

        // Pin drive per pair
        for (int i = 0; i < PAIRS; i++) begin
            nxt_st.high_pin_out[i] = pwm_high_src[i];
            nxt_st.low_pin_out[i] = st_ff.pair_independent[i] ? pwm_low_src[i]
                                                              : !pwm_high_src[i];
            nxt_st.high_pin_oe[i] = st_ff.high_pin_enable[i];
            nxt_st.low_pin_oe[i] = st_ff.low_pin_enable[i];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= STATE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs

    assign hreadyout = st_ff.hreadyout;
    assign hresp = 1'b0;
    assign hrdata = st_ff.hrdata;
    assign high_pin_out = st_ff.high_pin_out;
    assign high_pin_oe = st_ff.high_pin_oe;
    assign low_pin_out = st_ff.low_pin_out;
    assign low_pin_oe = st_ff.low_pin_oe;
    assign special_event = st_ff.special_event;
    assign timebase_event = st_ff.timebase_event;

endmodule : mpt_top

// >>> dv/mpt_top_props.sv
module mpt_top_props import mpt_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [2:0] pwm_high_src,
    input wire logic [2:0] pwm_low_src,
    input wire logic [2:0] high_pin_out,
    input wire logic [2:0] high_pin_oe,
    input wire logic [2:0] low_pin_out,
    input wire logic [2:0] low_pin_oe,
    input wire logic special_event
);
    timeunit 1ns;
    timeprecision 1ps;
    logic taken;
    logic [2:0] quiet_ff;
    assign taken = hsel && htrans[1] && hready;
    // Cycles since reset or since a write to the pair control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet_ff <= 3'h0;
        end else if (taken && hwrite && haddr == {24'h000000, OFS_CON1}) begin
            quiet_ff <= 3'h0;
        end else if (quiet_ff != 3'h7) begin
            quiet_ff <= quiet_ff + 3'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_wait_one;
        !hreadyout ##1 hreadyout;
    endsequence
    a_wait_one: assert property (taken |=> s_wait_one) else $error("wait state not one cycle");
    a_ready_hold: assert property (hreadyout && !taken |=> hreadyout) else $error("ready dropped");
    a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
    a_rdata_hold: assert property ($changed(hrdata) |-> $past(taken && !hwrite, 2)) else $error("read data moved");
    a_rdata_upper: assert property (hrdata[31:16] == 16'h0000) else $error("upper read bits set");
    a_high_follow: assert property ($past(hresetn) |-> high_pin_out == $past(pwm_high_src))
        else $error("high pin not its source");
    a_low_pair: assert property ($past(hresetn) |->
        ((low_pin_out ^ $past(pwm_low_src)) & (low_pin_out ^ ~high_pin_out)) == 3'h0)
        else $error("low pin neither source nor inverse");
    a_oe_quiet: assert property (quiet_ff > 3'h4 |-> $stable({high_pin_oe, low_pin_oe}))
        else $error("pin enable moved without write");
    a_sevt_pulse: assert property (special_event |=> !special_event) else $error("event too long");
endmodule : mpt_top_props
bind mpt_top mpt_top_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .hrdata, .pwm_high_src, .pwm_low_src, .high_pin_out, .high_pin_oe,
    .low_pin_out, .low_pin_oe, .special_event);

// >>> dv/mpt_gate_drv.sv
module mpt_gate_drv (
    input wire logic hclk,
    input wire logic [2:0] high_pin_out,
    input wire logic [2:0] high_pin_oe,
    input wire logic [2:0] low_pin_out,
    input wire logic [2:0] low_pin_oe,
    output logic [2:0] high_lvl,
    output logic [2:0] low_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] hlast_ff = 3'h0;
    logic [2:0] llast_ff = 3'h0;
    // Released pins float: show a level that flips every cycle
    assign high_lvl = (high_pin_out & high_pin_oe) | (~hlast_ff & ~high_pin_oe);
    assign low_lvl = (low_pin_out & low_pin_oe) | (~llast_ff & ~low_pin_oe);
    always @(posedge hclk) begin
        hlast_ff <= high_lvl;
        llast_ff <= low_lvl;
    end
endmodule : mpt_gate_drv

// >>> dv/mpt_top_tb.sv
module mpt_top_tb import mpt_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, idle = 1'b0, own = 1'b0, grd = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0] htrans = 2'h0, m;
    logic [2:0] hs = 3'h0, ls = 3'h0, ho, hoe, lo, loe, hl, ll;
    logic hreadyout, hresp, sev, tev;
    logic [31:0] hrdata;
    logic [1:0] mt [3] = '{MODE_FREE, MODE_UPDOWN, MODE_UPDOWN_DBL};
    int err_count = 0, cmp_count = 0, seed = 61, c, ck, ops, per;
    mpt_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cpu_idle(idle), .pin_reset_owner_cfg(own),
        .write_guard_cfg(grd), .pwm_high_src(hs), .pwm_low_src(ls), .high_pin_out(ho), .high_pin_oe(hoe),
        .low_pin_out(lo), .low_pin_oe(loe), .special_event(sev), .timebase_event(tev));
    mpt_gate_drv u_drv (.hclk, .high_pin_out(ho), .high_pin_oe(hoe), .low_pin_out(lo),
        .low_pin_oe(loe), .high_lvl(hl), .low_lvl(ll));
    always #4 hclk = ~hclk;
    ////////////////////////////////////////////////////////////////////////////
    task end_sim;
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wrdy;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : wrdy
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        wrdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wrdy();
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc
    task automatic unlock;
        wr(OFS_KEY, 32'h0000ABCD);
        wr(OFS_KEY, 32'h00004321);
    endtask : unlock
    task automatic tcfg(input logic [1:0] md, input int k, input int o, input int p);
        wr(OFS_TCON, 32'h0);
        wr(OFS_TMR, 32'h0);
        wr(OFS_TPER, p);
        wr(OFS_TCON, 32'h8000 | (o << 4) | (k << 2) | md);
    endtask : tcfg
    // Wait for one pulse, then count cycles to the next time base event
    task automatic span(input bit s, output int n);
        int k;
        k = 0;
        do begin
            @(negedge hclk);
            k++;
        end while ((s ? sev : tev) !== 1'b1 && k < 4000);
        if ((s ? sev : tev) !== 1'b1) err_count++;
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (tev !== 1'b1 && n < 4000);
    endtask : span
    function automatic int exp_iv(input logic [1:0] md, input int k, input int o, input int p);
        int t;
        t = (md == MODE_UPDOWN) ? 2 * p : (md == MODE_UPDOWN_DBL) ? p : p + 1;
        return t * (1 << (2 * k)) * (o + 1);
    endfunction : exp_iv
    function automatic logic [2:0] exp_low(input logic [2:0] h, input logic [2:0] l, input logic [2:0] pm);
        return (pm & l) | (~pm & ~h);
    endfunction : exp_low
    task automatic pins(input logic [15:0] v);
        repeat (8) begin
            @(posedge hclk);
            hs <= $random(seed);
            ls <= $random(seed);
            @(negedge hclk);
            @(negedge hclk);
            chk(ho, hs);
            chk(lo, exp_low(hs, ls, v[10:8]));
            chk({hoe, loe}, {v[6:4], v[2:0]});
            chk({hl & v[6:4], ll & v[2:0]}, {hs & v[6:4], exp_low(hs, ls, v[10:8]) & v[2:0]});
        end
    endtask : pins
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge hclk);
        err_count++;
        end_sim();
    end
    initial begin
        for (int r = 0; r < 2; r++) begin
            own <= r[0];
            grd <= r[0];
            hresetn <= 1'b0;
            repeat (3) @(posedge hclk);
            hresetn <= 1'b1;
            rdc(OFS_CON1, r ? 32'h0 : 32'h77);
            chk(hoe, r ? 3'h0 : 3'h7);
            rdc(OFS_TCON, 32'h0);
            rdc(OFS_TMR, 32'h0);
            rdc(OFS_TPER, 32'h0);
            rdc(OFS_SECMP, 32'h0);
            wr(OFS_CON1, 32'h0177);
            rdc(OFS_CON1, r ? 32'h0 : 32'h177);
        end
        unlock();
        rdc(OFS_TCON, 32'h0);
        wr(OFS_CON1, 32'h0177);
        rdc(OFS_CON1, 32'h0);
        unlock();
        wr(OFS_CON1, 32'hFFFFF9FF);
        rdc(OFS_CON1, 32'h0177);
        pins(16'h0177);
        unlock();
        wr(OFS_CON1, 32'h0652);
        rdc(OFS_CON1, 32'h0652);
        pins(16'h0652);
        wr(OFS_TCON, 32'hFFFF7FFF);
        rdc(OFS_TCON, 32'h20FF);
        wr(OFS_TPER, 32'hFFFFFFFF);
        rdc(OFS_TPER, 32'h7FFF);
        wr(OFS_SECMP, 32'hFFFFFFFF);
        rdc(OFS_SECMP, 32'hFFFF);
        wr(OFS_TMR, 32'hFFFF);
        rdc(OFS_TMR, 32'h7FFF);
        rdc(OFS_TMR, 32'h7FFF);
        rdc(OFS_KEY, 32'h0);
        wr(8'h18, 32'h1234);
        rdc(8'h18, 32'h0);
        for (int i = 0; i < 8; i++) begin
            m = mt[i % 3];
            ck = $random(seed) & 3;
            ops = $random(seed) & 1;
            per = 2 + ($random(seed) & 3);
            tcfg(m, ck, ops, per);
            span(1'b0, c);
            span(1'b0, c);
            chk(c, exp_iv(m, ck, ops, per));
        end
        tcfg(MODE_FREE, 0, 15, 2);
        span(1'b0, c);
        span(1'b0, c);
        chk(c, exp_iv(MODE_FREE, 0, 15, 2));
        tcfg(MODE_SINGLE, 0, 0, 4);
        span(1'b0, c);
        rdc(OFS_TCON, 32'h0001);
        rdc(OFS_TMR, 32'h0);
        idle <= 1'b1;
        tcfg(MODE_FREE, 0, 0, 3);
        wr(OFS_TCON, 32'hA000);
        wr(OFS_TMR, 32'h1);
        rdc(OFS_TMR, 32'h1);
        wr(OFS_TCON, 32'h8000);
        span(1'b0, c);
        span(1'b0, c);
        chk(c, 32'h4);
        idle <= 1'b0;
        for (int d = 0; d < 2; d++) begin
            wr(OFS_SECMP, (d << 15) | 3);
            tcfg(MODE_UPDOWN, 0, 0, 5);
            span(1'b1, c);
            chk(c < 5, d);
        end
        end_sim();
    end
endmodule : mpt_top_tb
